// File: bench/host_side_model.sv
/*
  Host processor side of the error pins: it pulls the pins low on request.
  Assumes the bus error wire is open drain with a pull-up, shared with the block.
*/
`timescale 1ns/1ns
module host_side_model
(
  // Requests from the bench to assert the processor's error pins.
  input  wire logic bus_err_req,
  input  wire logic int_err_req,
  // The block's own drive of the bus error wire.
  input  wire logic dut_out,
  input  wire logic dut_oe_n,
  // Resolved pin levels seen by the block.
  output logic      bus_err_level,
  output logic      int_err_level
);
  // ****************************************************************
  // Wire resolution
  // ****************************************************************
  // Either party may pull the wire low; otherwise the pull-up wins.
  assign bus_err_level = !bus_err_req && (dut_oe_n ? 1'b1 : dut_out);
  assign int_err_level = !int_err_req;
endmodule

// File: bench/testbench.sv
/*
  Self-checking bench for the host bus error status register.
  Assumes the register at 0xe0, as the package states, with one APB wait state, as the block states.
*/
`timescale 1ns/1ns
module testbench;
  import err_status_pkg::*;
  logic core_clk = 1'b0;
  logic srst     = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb  = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, processor_bus_error_signal_in, processor_bus_error_signal_out, processor_bus_error_signal_oe_n, processor_internal_error_signal_n, msg_req;
  logic bus_req = 1'b0, int_req = 1'b0;
  logic ecc_v = 1'b0, ecc_m = 1'b0;
  logic [7:0]  ecc_s = 8'h00;
  logic [31:0] rd;
  logic        err;
  logic        strap = 1'b1;
  int n_mismatch = 0, cmp_count = 0, n_req = 0, n_drv = 0, cycles = 0;

  // ****************************************************************
  // Clock, units and monitors
  // ****************************************************************
  always #20 core_clk = ~core_clk;
  host_bus_error_status dut (.CORE_CLK(core_clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BUS_ERR_N_IN(processor_bus_error_signal_in),
    .BUS_ERR_N_OUT(processor_bus_error_signal_out), .BUS_ERR_N_OE_N(processor_bus_error_signal_oe_n), .INT_ERR_N(processor_internal_error_signal_n),
    .ECC_STRAP(strap), .ECC_ERR_VALID(ecc_v), .ECC_ERR_MULTI(ecc_m),
    .ECC_ERR_SYNDROME(ecc_s), .HOST_ERR_MSG_REQ(msg_req));
  host_side_model host (.bus_err_req(bus_req), .int_err_req(int_req), .dut_out(processor_bus_error_signal_out),
    .dut_oe_n(processor_bus_error_signal_oe_n), .bus_err_level(processor_bus_error_signal_in), .int_err_level(processor_internal_error_signal_n));

  // Counting pulses here avoids racing the bench against one-cycle outputs.
  always @(posedge core_clk)
  begin
    cycles++;
    if (msg_req === 1'b1) n_req++;
    if (processor_bus_error_signal_oe_n === 1'b0 && processor_bus_error_signal_out === 1'b0) n_drv++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic end_of_test();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic ecc(input logic m, input logic [7:0] s);
    @(posedge core_clk);
    ecc_v <= 1'b1; ecc_m <= m; ecc_s <= s;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    ecc_v <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_reset_and_map();
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_0100);
    apb(1'b0, 8'he4, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask

  task automatic sc_pin_errors();
    bus_req <= 1'b1; int_req <= 1'b1;
    idle(6);
    bus_req <= 1'b0; int_req <= 1'b0;
    idle(4);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_0100);
    chk(n_req, 0);
    apb(1'b1, HOST_ERR_ADDR, 32'h0000_ffff, 4'h1);
    apb(1'b1, HOST_ERR_ADDR, 32'h0000_0800, 4'h2);
    bus_req <= 1'b1;
    idle(5);
    bus_req <= 1'b0;
    idle(4);
    int_req <= 1'b1;
    idle(5);
    int_req <= 1'b0;
    idle(4);
    chk(n_req, 2);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_c900);
    apb(1'b1, HOST_ERR_ADDR, 32'h0000_0800, 4'h2);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_c900);
    apb(1'b1, HOST_ERR_ADDR, 32'h0000_c800, 4'h2);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_0900);
  endtask

  // Detection is switched off here, since the block's own drive is also a bus error.
  task automatic sc_syndrome();
    apb(1'b1, HOST_ERR_ADDR, 32'h0000_0200, 4'h2);
    n_drv = 0;
    ecc(1'b0, 8'h5a);
    ecc(1'b1, 8'h33);
    ecc(1'b0, 8'h11);
    idle(3);
    chk(n_drv, 1);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_0733);
    ecc(1'b0, 8'h44);
    idle(2);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_0744);
    ecc(1'b0, 8'h55);
    idle(2);
    apb(1'b1, HOST_ERR_ADDR, 32'h0000_0000, 4'h2);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_0555);
    ecc(1'b1, 8'h77);
    idle(3);
    chk(n_drv, 1);
    apb(1'b1, HOST_ERR_ADDR, 32'h0000_0400, 4'h2);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_0177);
  endtask

  // A write-one clear lands on the edge of a new uncorrectable event; the set must win.
  task automatic sc_set_wins();
    fork
      apb(1'b1, HOST_ERR_ADDR, 32'h0000_0400, 4'h2);
      begin
        repeat (3) @(posedge core_clk);
        ecc_v <= 1'b1;
        ecc_m <= 1'b1;
        ecc_s <= 8'h3c;
        @(posedge core_clk);
        ecc_v <= 1'b0;
      end
    join
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_053c);
  endtask

  // A second reset with the strap low: every field, strap status included, reads zero.
  task automatic sc_strap_low();
    @(posedge core_clk);
    strap <= 1'b0;
    srst  <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    idle(2);
    apb(1'b0, HOST_ERR_ADDR, 32'h0, 4'h0);
    chk(rd, 32'h0000_0000);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    idle(2);
    sc_reset_and_map();
    sc_pin_errors();
    sc_syndrome();
    sc_set_wins();
    sc_strap_low();
    end_of_test();
  end
endmodule

// File: logic/err_status_pkg.sv
/*
  Shared constants and types for the host bus error control and status block:
  register address, field positions, reset value and the syndrome lock states.
  Assumes an APB slave with 8-bit byte addresses and 32-bit data.
*/
package err_status_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int unsigned APB_AW    = 8;
  localparam int unsigned APB_DW    = 32;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned SYN_W     = 8;
  localparam int unsigned PIN_COUNT = 3;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0]  HOST_ERR_ADDR       = 8'he0;
  localparam logic [15:0] HOST_ERR_RESET      = 16'h0000;
  localparam int unsigned BUS_ERR_FLAG_BIT    = 15;
  localparam int unsigned INT_ERR_FLAG_BIT    = 14;
  localparam int unsigned DETECT_EN_BIT       = 11;
  localparam int unsigned UNCORR_FLAG_BIT     = 10;
  localparam int unsigned UNCORR_DRIVE_EN_BIT = 9;
  localparam int unsigned STRAP_BIT           = 8;
  localparam int unsigned SYN_LSB             = 0;
  localparam int unsigned CTL_LANE            = 1;

  // ****************************************************************
  // Pin order inside the synchroniser
  // ****************************************************************
  localparam int unsigned PIN_BUS_ERR = 0;
  localparam int unsigned PIN_INT_ERR = 1;
  localparam int unsigned PIN_STRAP   = 2;

  // Syndrome field lock states.
  typedef enum logic [1:0] {SYN_OPEN, SYN_HELD_SINGLE, SYN_HELD_MULTI} syn_state_t;

endpackage

// File: logic/host_bus_error_status.sv
/*
  Host bus error control and status register with APB access, error pin
  detection, uncorrectable error flagging, bus error drive and syndrome lock.
  Assumes the error pins are asynchronous and active low, the strap is stable
  across reset, and the ECC checker reports events on the core clock.
*/
`timescale 1ns/1ns

// Function
// - A detected bus error on the host bus sets the bus error flag at bit 15.
// - A detected internal error on the host bus sets the internal error flag at bit 14.
// - The register is 16 bits at offset E0h and resets to zero.
// - The internal error flag clears only on a written one; a written zero keeps it.
// - Bit 11 enables detection of the bus error and internal error pins.
// - An enabled host error detection produces a request toward the message logic.
// - An uncorrectable host bus error sets bit 10, cleared only by a written one.
// - Bit 9 lets an uncorrectable error drive the bus error pin; zero keeps it off.
// - Read-only bit 8 shows the latched ECC generation strap.
// - A host bus ECC error loads its syndrome into bits 7:0.
// - A loaded syndrome stays locked until software reads it; the read unlocks it.
// - A multiple-bit error overwrites a locked single-bit syndrome.
// - Any other error before the read is not recorded in the syndrome.
module host_bus_error_status
  import err_status_pkg::*;
(
  // Clock and synchronous reset.
  input  wire logic              CORE_CLK,
  input  wire logic              SRST,
  // APB slave.
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [APB_AW-1:0] PADDR,
  input  wire logic [APB_DW-1:0] PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [APB_DW-1:0] PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Host bus error pins, active low; the bus error pin is open drain.
  input  wire logic              BUS_ERR_N_IN,
  output logic                   BUS_ERR_N_OUT,
  output logic                   BUS_ERR_N_OE_N,
  input  wire logic              INT_ERR_N,
  // ECC generation strap.
  input  wire logic              ECC_STRAP,
  // ECC checker events.
  input  wire logic              ECC_ERR_VALID,
  input  wire logic              ECC_ERR_MULTI,
  input  wire logic [SYN_W-1:0]  ECC_ERR_SYNDROME,
  // Request toward the message selection logic.
  output logic                   HOST_ERR_MSG_REQ
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  syn_if syn ();

  logic [PIN_COUNT-1:0] pins_sync;
  logic                 bus_err_seen;
  logic                 int_err_seen;

  logic                 bus_flag_reg;
  logic                 bus_flag_next;
  logic                 int_flag_reg;
  logic                 int_flag_next;
  logic                 uncorr_flag_reg;
  logic                 uncorr_flag_next;
  logic                 detect_en_reg;
  logic                 detect_en_next;
  logic                 drive_en_reg;
  logic                 drive_en_next;
  logic                 strap_reg;
  logic                 strap_next;
  logic                 strap_taken_reg;
  logic                 strap_taken_next;

  logic                 drive_reg;
  logic                 drive_next;
  logic                 msg_reg;
  logic                 msg_next;
  logic                 err_seen_reg;
  logic                 err_seen_next;

  logic                 pready_reg;
  logic                 pready_next;
  logic                 pslverr_reg;
  logic                 pslverr_next;
  logic [APB_DW-1:0]    prdata_reg;
  logic [APB_DW-1:0]    prdata_next;
  logic                 snap_ok_reg;
  logic                 snap_ok_next;

  logic                 done;
  logic                 hit;
  logic                 wr_ctl;
  logic [REG_W-1:0]     reg_view;
  logic                 uncorr_event;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // A write-one clear that never loses a concurrent set.
  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    w1c = set | (cur & ~clr);
  endfunction

  // ****************************************************************
  // Pin synchronisers and syndrome unit
  // ****************************************************************
  pin_sync u_pin_sync (
    .clk (CORE_CLK),
    .d   ({ECC_STRAP, INT_ERR_N, BUS_ERR_N_IN}),
    .q   (pins_sync)
  );

  syndrome_capture u_syn (
    .clk  (CORE_CLK),
    .rst  (SRST),
    .port (syn.capture)
  );

  // Feed the checker events and the read release into the syndrome unit.
  assign syn.ecc_valid    = ECC_ERR_VALID;
  assign syn.ecc_multi    = ECC_ERR_MULTI;
  assign syn.ecc_syn      = ECC_ERR_SYNDROME;
  assign syn.read_release = done && !PWRITE && hit && snap_ok_reg;

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  // An access completes only at the edge where the ready flop is high.
  assign done   = PSEL && PENABLE && pready_reg;
  assign hit    = (PADDR == HOST_ERR_ADDR);
  assign wr_ctl = done && PWRITE && hit && PSTRB[CTL_LANE];

  // Register image; bits 13:12 are reserved and read as zero.
  always_comb
  begin
    reg_view                          = HOST_ERR_RESET;
    reg_view[BUS_ERR_FLAG_BIT]        = bus_flag_reg;
    reg_view[INT_ERR_FLAG_BIT]        = int_flag_reg;
    reg_view[DETECT_EN_BIT]           = detect_en_reg;
    reg_view[UNCORR_FLAG_BIT]         = uncorr_flag_reg;
    reg_view[UNCORR_DRIVE_EN_BIT]     = drive_en_reg;
    reg_view[STRAP_BIT]               = strap_reg;
    reg_view[SYN_LSB +: SYN_W]        = syn.syn_value;
  end

  // ****************************************************************
  // Error detection
  // ****************************************************************

  // Pins are active low; detection is gated by the enable bit.
  assign bus_err_seen = detect_en_reg && !pins_sync[PIN_BUS_ERR];
  assign int_err_seen = detect_en_reg && !pins_sync[PIN_INT_ERR];
  assign uncorr_event = ECC_ERR_VALID && ECC_ERR_MULTI;

  // ****************************************************************
  // Register state
  // ****************************************************************

  // Control bits take byte lane one; flags use write-one clear.
  always_comb
  begin
    bus_flag_next    = w1c(bus_flag_reg, bus_err_seen,
                           wr_ctl && PWDATA[BUS_ERR_FLAG_BIT]);
    int_flag_next    = w1c(int_flag_reg, int_err_seen,
                           wr_ctl && PWDATA[INT_ERR_FLAG_BIT]);
    uncorr_flag_next = w1c(uncorr_flag_reg, uncorr_event,
                           wr_ctl && PWDATA[UNCORR_FLAG_BIT]);
    detect_en_next   = wr_ctl ? PWDATA[DETECT_EN_BIT] : detect_en_reg;
    drive_en_next    = wr_ctl ? PWDATA[UNCORR_DRIVE_EN_BIT] : drive_en_reg;
    strap_taken_next = 1'b1;
    strap_next       = strap_taken_reg ? strap_reg : pins_sync[PIN_STRAP];
  end

  // The strap is caught once, on the first clock after reset release.
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      bus_flag_reg    <= HOST_ERR_RESET[BUS_ERR_FLAG_BIT];
      int_flag_reg    <= HOST_ERR_RESET[INT_ERR_FLAG_BIT];
      uncorr_flag_reg <= HOST_ERR_RESET[UNCORR_FLAG_BIT];
      detect_en_reg   <= HOST_ERR_RESET[DETECT_EN_BIT];
      drive_en_reg    <= HOST_ERR_RESET[UNCORR_DRIVE_EN_BIT];
      strap_reg       <= HOST_ERR_RESET[STRAP_BIT];
      strap_taken_reg <= 1'b0;
    end
    else
    begin
      bus_flag_reg    <= bus_flag_next;
      int_flag_reg    <= int_flag_next;
      uncorr_flag_reg <= uncorr_flag_next;
      detect_en_reg   <= detect_en_next;
      drive_en_reg    <= drive_en_next;
      strap_reg       <= strap_next;
      strap_taken_reg <= strap_taken_next;
    end
  end

  // ****************************************************************
  // Pin drive and message request
  // ****************************************************************

  // Drive for one cycle per uncorrectable event; the request fires on the
  // first cycle of a detected condition so a held pin asks only once.
  always_comb
  begin
    drive_next    = uncorr_event && drive_en_reg;
    err_seen_next = bus_err_seen || int_err_seen;
    msg_next      = err_seen_next && !err_seen_reg;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      drive_reg    <= 1'b0;
      msg_reg      <= 1'b0;
      err_seen_reg <= 1'b0;
    end
    else
    begin
      drive_reg    <= drive_next;
      msg_reg      <= msg_next;
      err_seen_reg <= err_seen_next;
    end
  end

  // ****************************************************************
  // APB answer
  // ****************************************************************

  // One wait state: read data are snapped on the edge that raises ready so they
  // stand still while the master samples them. A syndrome loaded at or after
  // the snap voids the release, so software never unlocks a value it missed.
  always_comb
  begin
    pready_next  = PSEL && PENABLE && !pready_reg;
    pslverr_next = pready_next && !hit;
    prdata_next  = prdata_reg;
    snap_ok_next = snap_ok_reg && !syn.update;
    if (pready_next)
    begin
      prdata_next  = (hit && !PWRITE) ? {{(APB_DW-REG_W){1'b0}}, reg_view} : '0;
      snap_ok_next = !syn.update;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
      snap_ok_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
      snap_ok_reg <= snap_ok_next;
    end
  end

  assign PREADY           = pready_reg;
  assign PSLVERR          = pslverr_reg;
  assign PRDATA           = prdata_reg;
  assign BUS_ERR_N_OUT    = ~drive_reg;
  assign BUS_ERR_N_OE_N   = ~drive_reg;
  assign HOST_ERR_MSG_REQ = msg_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence write_one(int unsigned b);
    wr_ctl && PWDATA[b];
  endsequence

  sequence held_single_hit_multi;
    syn.state == SYN_HELD_SINGLE ##0 uncorr_event;
  endsequence

  reset_zero_a: assert property (@(posedge CORE_CLK)
    SRST |=> (reg_view[REG_W-1:STRAP_BIT+1] == HOST_ERR_RESET[REG_W-1:STRAP_BIT+1]))
    else $error("register not zero after reset");

  bus_flag_set_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    bus_err_seen |=> bus_flag_reg)
    else $error("bus error not flagged");

  int_flag_set_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    int_err_seen |=> int_flag_reg)
    else $error("internal error not flagged");

  int_zero_keep_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (int_flag_reg && !(wr_ctl && PWDATA[INT_ERR_FLAG_BIT])) |=> int_flag_reg)
    else $error("internal error flag lost without a written one");

  detect_off_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!detect_en_reg && !bus_flag_reg && !int_flag_reg) |=> (!bus_flag_reg && !int_flag_reg))
    else $error("flag set while detection disabled");

  msg_request_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (bus_err_seen && !err_seen_reg) |=> HOST_ERR_MSG_REQ ##1 !HOST_ERR_MSG_REQ)
    else $error("message request not a single pulse");

  uncorr_flag_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    uncorr_event |=> uncorr_flag_reg)
    else $error("uncorrectable error not flagged");

  drive_pin_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (uncorr_event && drive_en_reg) |=> (!BUS_ERR_N_OE_N && !BUS_ERR_N_OUT)
      ##1 (BUS_ERR_N_OE_N || $past(drive_next)))
    else $error("bus error pin drive wrong");

  no_drive_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !drive_en_reg |=> BUS_ERR_N_OE_N)
    else $error("bus error pin driven while disabled");

  strap_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    strap_taken_reg |=> $stable(strap_reg))
    else $error("strap bit changed after capture");

  syn_load_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (syn.state == SYN_OPEN && ECC_ERR_VALID) |=> (syn.syn_value == $past(ECC_ERR_SYNDROME)))
    else $error("syndrome not loaded");

  syn_release_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (syn.read_release && !syn.update) |=> syn.state == SYN_OPEN)
    else $error("syndrome lock not released by read");

  syn_over_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    held_single_hit_multi |=> (syn.state == SYN_HELD_MULTI &&
      syn.syn_value == $past(ECC_ERR_SYNDROME)))
    else $error("multiple-bit error did not overwrite single-bit syndrome");

  syn_locked_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (syn.state != SYN_OPEN && !syn.update) |=> $stable(syn.syn_value))
    else $error("locked syndrome changed");

  set_wins_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (write_one(UNCORR_FLAG_BIT) and uncorr_event) |=> uncorr_flag_reg)
    else $error("concurrent set lost to clear");

endmodule

// File: logic/pin_sync.sv
/*
  Two-flop synchroniser for the asynchronous input pins.
  Assumes the pins are quasi-static or slow against the core clock.
*/
`timescale 1ns/1ns
module pin_sync
  import err_status_pkg::*;
(
  // Clock.
  input  wire logic                 clk,
  // Raw pins and their synchronised copies.
  input  wire logic [PIN_COUNT-1:0] d,
  output logic      [PIN_COUNT-1:0] q
);

  logic [PIN_COUNT-1:0] stage1_reg;
  logic [PIN_COUNT-1:0] stage2_reg;

  // The first stage feeds only the second; no reset so straps keep flowing.
  always_ff @(posedge clk)
  begin
    stage1_reg <= d;
    stage2_reg <= stage1_reg;
  end

  assign q = stage2_reg;

endmodule

// File: logic/syn_if.sv
/*
  Carrier between the register logic and the syndrome capture unit.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/1ns
interface syn_if;
  import err_status_pkg::*;
  logic               ecc_valid;
  logic               ecc_multi;
  logic [SYN_W-1:0]   ecc_syn;
  logic               read_release;
  logic [SYN_W-1:0]   syn_value;
  logic               update;
  syn_state_t         state;

  modport capture (input ecc_valid, ecc_multi, ecc_syn, read_release,
                   output syn_value, update, state);
  modport host    (output ecc_valid, ecc_multi, ecc_syn, read_release,
                   input syn_value, update, state);
endinterface

// File: logic/syndrome_capture.sv
/*
  Syndrome capture with read release lock and single-to-multiple overwrite.
  Assumes error events and the release strobe come from core clock logic.
*/
`timescale 1ns/1ns
module syndrome_capture
  import err_status_pkg::*;
(
  // Clock and synchronous reset.
  input  wire logic clk,
  input  wire logic rst,
  // Link to the register logic.
  syn_if.capture    port
);

  syn_state_t       state_reg;
  syn_state_t       state_next;
  logic [SYN_W-1:0] syn_reg;
  logic [SYN_W-1:0] syn_next;
  logic             load;

  // A multiple-bit event on a held single-bit syndrome beats a release arriving in the same cycle.
  always_comb
  begin
    state_next = state_reg;
    syn_next   = syn_reg;
    load       = 1'b0;
    case (state_reg)
      SYN_OPEN:
        load = port.ecc_valid;
      SYN_HELD_SINGLE:
        if (port.ecc_valid && port.ecc_multi)
          load = 1'b1;
        else if (port.read_release)
          state_next = SYN_OPEN;
      SYN_HELD_MULTI:
        if (port.read_release)
          state_next = SYN_OPEN;
      default:
        state_next = SYN_OPEN;
    endcase
    if (load)
    begin
      syn_next   = port.ecc_syn;
      state_next = port.ecc_multi ? SYN_HELD_MULTI : SYN_HELD_SINGLE;
    end
  end

  // Single-bit events while held, and any event while a multiple-bit syndrome is held, are not loaded.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= SYN_OPEN;
      syn_reg   <= HOST_ERR_RESET[SYN_W-1:0];
    end
    else
    begin
      state_reg <= state_next;
      syn_reg   <= syn_next;
    end
  end

  assign port.syn_value = syn_reg;
  assign port.update    = load;
  assign port.state     = state_reg;

endmodule
